// File: ipr_cfg.svh
`ifndef IPR_CFG_SVH
`define IPR_CFG_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define IPR_OFS_A 4'h0
`define IPR_OFS_B 4'h2
`define IPR_OFS_C 4'h4
`define IPR_OFS_D 4'h6

// ****************************************************************
// Reset value and writable bit masks
// ****************************************************************
`define IPR_RESET_VAL 16'h0000
`define IPR_MASK_A 16'h0FF0
`define IPR_MASK_B 16'hFF00
`define IPR_MASK_C 16'hFFFF
`define IPR_MASK_D 16'hFFFF

// ****************************************************************
// Field positions (low bit of each nibble)
// ****************************************************************
`define IPR_DMA_LSB 8
`define IPR_WATCHDOG_LSB 4
`define IPR_ETH_LSB 12
`define IPR_FREERUN_LSB 8
`define IPR_EXT0_LSB 12
`define IPR_EXT1_LSB 8
`define IPR_EXT2_LSB 4
`define IPR_EXT3_LSB 0
`define IPR_PT0_LSB 12
`define IPR_PT1_LSB 8
`define IPR_PT2_LSB 4
`define IPR_SER1_LSB 0

`endif

// File: ipr_pkg.sv
package ipr_pkg;

    // One priority level: 0 is lowest, 15 highest
    typedef logic [3:0] ipr_level_t;

    // Index of each priority register in the bank
    typedef enum logic [1:0] {
        IPR_REG_A = 2'b00,
        IPR_REG_B = 2'b01,
        IPR_REG_C = 2'b10,
        IPR_REG_D = 2'b11
    } ipr_reg_e;

    typedef logic [15:0] ipr_word_t;

endpackage

// File: ipr_tiebreak.sv
`timescale 1ns/1ps

// Fixed order between sources sharing one level field
module ipr_tiebreak (
    // DMA channel requests
    input wire logic [1:0] dma_req_i,
    // Watchdog and bus-state requests
    input wire logic watchdog_req_i,
    input wire logic bus_state_req_i,
    // Selected source per shared field
    output logic [1:0] dma_serve_o,
    output logic watchdog_serve_o,
    output logic bus_state_serve_o
);

    always_comb begin
        dma_serve_o = 2'h0;
        if (dma_req_i[0]) begin
            dma_serve_o = 2'h1;
        end else if (dma_req_i[1]) begin
            dma_serve_o = 2'h2;
        end
    end

    always_comb begin
        watchdog_serve_o = watchdog_req_i;
        bus_state_serve_o = bus_state_req_i && !watchdog_req_i;
    end

endmodule

// File: ipr_regs.sv
`timescale 1ns/1ps
`include "ipr_cfg.svh"

module ipr_regs (
    // Clock and resets
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic manual_nrst_i,
    // Power state
    input wire logic standby_i,
    // Register port
    input wire logic [3:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    // Request sources sharing a field
    input wire logic [1:0] dma_req_i,
    input wire logic watchdog_req_i,
    input wire logic bus_state_req_i,
    output logic [1:0] dma_serve_o,
    output logic watchdog_serve_o,
    output logic bus_state_serve_o,
    // Levels to arbitration
    output ipr_pkg::ipr_level_t dma_level_o,
    output ipr_pkg::ipr_level_t watchdog_level_o,
    output ipr_pkg::ipr_level_t eth_dma_level_o,
    output ipr_pkg::ipr_level_t freerun_timer_level_o,
    output ipr_pkg::ipr_level_t ext_line0_level_o,
    output ipr_pkg::ipr_level_t ext_line1_level_o,
    output ipr_pkg::ipr_level_t ext_line2_level_o,
    output ipr_pkg::ipr_level_t ext_line3_level_o,
    output ipr_pkg::ipr_level_t pulse_timer0_level_o,
    output ipr_pkg::ipr_level_t pulse_timer1_level_o,
    output ipr_pkg::ipr_level_t pulse_timer2_level_o,
    output ipr_pkg::ipr_level_t fifo_serial1_level_o
);

    // ****************************************************************
    // Register storage
    // ****************************************************************
    localparam ipr_pkg::ipr_word_t MASKS [4] = '{
        `IPR_MASK_A, `IPR_MASK_B, `IPR_MASK_C, `IPR_MASK_D
    };

    ipr_pkg::ipr_word_t bank [4];
    ipr_pkg::ipr_reg_e sel;
    logic hit;
    logic [3:0] wr_sel;
    ipr_pkg::ipr_word_t next_rdata;

    // ****************************************************************
    // Address decode
    // ****************************************************************
    always_comb begin
        hit = 1'b1;
        sel = ipr_pkg::IPR_REG_A;
        if (addr_i == `IPR_OFS_A) begin
            sel = ipr_pkg::IPR_REG_A;
        end else if (addr_i == `IPR_OFS_B) begin
            sel = ipr_pkg::IPR_REG_B;
        end else if (addr_i == `IPR_OFS_C) begin
            sel = ipr_pkg::IPR_REG_C;
        end else if (addr_i == `IPR_OFS_D) begin
            sel = ipr_pkg::IPR_REG_D;
        end else begin
            hit = 1'b0;
        end
    end

    // ****************************************************************
    // Per-register write and clear
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : gen_reg
            assign wr_sel[g] = wr_i && hit && (sel == ipr_pkg::ipr_reg_e'(g));

            // Standby is deliberately not an input here: contents survive it
            // only resets clear
            always_ff @(posedge clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    bank[g] <= `IPR_RESET_VAL;
                end else if (!manual_nrst_i) begin
                    bank[g] <= `IPR_RESET_VAL;
                end else if (wr_sel[g]) begin
                    bank[g] <= wdata_i & MASKS[g];
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Read port
    // ****************************************************************
    // Unmapped offsets read zero rather than aliasing
    always_comb begin
        next_rdata = 16'h0000;
        if (rd_i && hit) begin
            next_rdata = bank[sel];
        end
    end

    // Data stands for exactly the cycle after the strobe
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_o <= 16'h0000;
        end else begin
            rdata_o <= next_rdata;
        end
    end

    // ****************************************************************
    // Level outputs
    // ****************************************************************
    // raw level, zero lowest
    assign dma_level_o = bank[0][`IPR_DMA_LSB +: 4];
    assign watchdog_level_o = bank[0][`IPR_WATCHDOG_LSB +: 4];
    assign eth_dma_level_o = bank[1][`IPR_ETH_LSB +: 4];
    assign freerun_timer_level_o = bank[1][`IPR_FREERUN_LSB +: 4];
    // external lines, line 0 on top
    assign ext_line0_level_o = bank[2][`IPR_EXT0_LSB +: 4];
    assign ext_line1_level_o = bank[2][`IPR_EXT1_LSB +: 4];
    assign ext_line2_level_o = bank[2][`IPR_EXT2_LSB +: 4];
    assign ext_line3_level_o = bank[2][`IPR_EXT3_LSB +: 4];
    assign pulse_timer0_level_o = bank[3][`IPR_PT0_LSB +: 4];
    assign pulse_timer1_level_o = bank[3][`IPR_PT1_LSB +: 4];
    assign pulse_timer2_level_o = bank[3][`IPR_PT2_LSB +: 4];
    assign fifo_serial1_level_o = bank[3][`IPR_SER1_LSB +: 4];

    // ****************************************************************
    // Order within shared fields
    // ****************************************************************
    // fixed tie order
    ipr_tiebreak u_tiebreak (
        .dma_req_i(dma_req_i),
        .watchdog_req_i(watchdog_req_i),
        .bus_state_req_i(bus_state_req_i),
        .dma_serve_o(dma_serve_o),
        .watchdog_serve_o(watchdog_serve_o),
        .bus_state_serve_o(bus_state_serve_o)
    );

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    sequence s_wr_a;
        wr_i && addr_i == `IPR_OFS_A && manual_nrst_i;
    endsequence

    sequence s_rd_a;
        rd_i && addr_i == `IPR_OFS_A && manual_nrst_i;
    endsequence

    sequence s_wr_b;
        wr_i && addr_i == `IPR_OFS_B && manual_nrst_i;
    endsequence

    sequence s_rd_b;
        rd_i && addr_i == `IPR_OFS_B && manual_nrst_i;
    endsequence

    sequence s_wr_c;
        wr_i && addr_i == `IPR_OFS_C && manual_nrst_i;
    endsequence

    sequence s_rd_c;
        rd_i && addr_i == `IPR_OFS_C && manual_nrst_i;
    endsequence

    sequence s_rd_d;
        rd_i && addr_i == `IPR_OFS_D && manual_nrst_i;
    endsequence

    a_manual_clear_all: assert property (
        !manual_nrst_i |=> bank[0] == 16'h0000 && bank[1] == 16'h0000
            && bank[2] == 16'h0000 && bank[3] == 16'h0000
    ) else $error("manual reset left a level register non-zero");

    a_manual_clear_levels: assert property (
        !manual_nrst_i ##1 !wr_i [*2] |-> dma_level_o == 4'h0
            && ext_line0_level_o == 4'h0 && fifo_serial1_level_o == 4'h0
    ) else $error("levels not zero after manual reset");

    a_standby_hold: assert property (
        standby_i && !wr_i && manual_nrst_i |=> $stable(bank[0])
            && $stable(bank[1]) && $stable(bank[2]) && $stable(bank[3])
    ) else $error("standby changed a level register");

    a_reserved_read_a: assert property (
        s_wr_a ##1 s_rd_a |=> rdata_o[15:12] == 4'h0 && rdata_o[3:0] == 4'h0
    ) else $error("reserved bits of register A read non-zero");

    a_reserved_read_b: assert property (
        s_wr_b ##1 s_rd_b |=> rdata_o[7:0] == 8'h00
    ) else $error("reserved bits of register B read non-zero");

    a_field_roundtrip: assert property (
        s_wr_a ##1 s_rd_a |=> rdata_o == ($past(wdata_i, 2) & 16'h0FF0)
    ) else $error("register A did not return the written levels");

    a_dma_level_follow: assert property (
        s_wr_a |=> dma_level_o == $past(wdata_i[11:8])
    ) else $error("DMA level does not follow register A");

    a_dma_ch0_first: assert property (
        dma_req_i == 2'h3 |-> dma_serve_o == 2'h1
    ) else $error("DMA channel 1 served ahead of channel 0");

    a_watchdog_level_follow: assert property (
        s_wr_a |=> watchdog_level_o == $past(wdata_i[7:4])
    ) else $error("watchdog level does not follow register A");

    a_watchdog_first: assert property (
        watchdog_req_i && bus_state_req_i |-> watchdog_serve_o && !bus_state_serve_o
    ) else $error("bus-state source served ahead of watchdog");

    a_eth_level_follow: assert property (
        s_wr_b |=> eth_dma_level_o == $past(wdata_i[15:12])
    ) else $error("Ethernet DMA level does not follow register B");

    a_timer_level_follow: assert property (
        s_wr_b |=> freerun_timer_level_o == $past(wdata_i[11:8])
    ) else $error("timer level does not follow register B");

    a_ext_line_order: assert property (
        wr_i && addr_i == `IPR_OFS_C && manual_nrst_i |=>
            {ext_line0_level_o, ext_line1_level_o, ext_line2_level_o,
             ext_line3_level_o} == $past(wdata_i)
    ) else $error("external line levels out of order");

    a_pulse_timer_order: assert property (
        wr_i && addr_i == `IPR_OFS_D && manual_nrst_i |=>
            {pulse_timer0_level_o, pulse_timer1_level_o, pulse_timer2_level_o}
            == $past(wdata_i[15:4])
    ) else $error("pulse timer levels out of order");

    a_serial_level: assert property (
        wr_i && addr_i == `IPR_OFS_D && manual_nrst_i |=>
            fifo_serial1_level_o == $past(wdata_i[3:0])
    ) else $error("serial level does not follow register D");

    a_level_hold: assert property (
        !wr_i && manual_nrst_i |=> $stable(pulse_timer1_level_o)
            && $stable(ext_line2_level_o) && $stable(watchdog_level_o)
    ) else $error("a level moved without a write");

    a_top_level: assert property (
        wr_i && addr_i == `IPR_OFS_C && manual_nrst_i && wdata_i[15:12] == 4'hF
            |=> ext_line0_level_o == 4'hF
    ) else $error("highest level not presented as fifteen");

    a_read_one_cycle: assert property (
        !rd_i |=> rdata_o == 16'h0000
    ) else $error("read data stood beyond its cycle");

    a_full_roundtrip_c: assert property (
        s_wr_c ##1 s_rd_c |=> rdata_o == $past(wdata_i, 2)
    ) else $error("register C did not return the written levels");

    // Software must see exactly what arbitration sees
    a_read_a_levels: assert property (
        s_rd_a |=> rdata_o[11:4] == $past({dma_level_o, watchdog_level_o})
    ) else $error("register A read differs from its level outputs");

    a_read_b_levels: assert property (
        s_rd_b |=> rdata_o[15:8] == $past({eth_dma_level_o,
            freerun_timer_level_o})
    ) else $error("register B read differs from its level outputs");

    a_read_c_levels: assert property (
        s_rd_c |=> rdata_o == $past({ext_line0_level_o, ext_line1_level_o,
            ext_line2_level_o, ext_line3_level_o})
    ) else $error("register C read differs from its level outputs");

    a_read_d_levels: assert property (
        s_rd_d |=> rdata_o == $past({pulse_timer0_level_o, pulse_timer1_level_o,
            pulse_timer2_level_o, fifo_serial1_level_o})
    ) else $error("register D read differs from its level outputs");

    a_reserved_hold_a: assert property (
        bank[0][15:12] == 4'h0 && bank[0][3:0] == 4'h0
    ) else $error("reserved bits of register A hold a one");

    a_reserved_hold_b: assert property (
        bank[1][7:0] == 8'h00
    ) else $error("reserved bits of register B hold a one");

    a_standby_write: assert property (
        standby_i && wr_i && addr_i == `IPR_OFS_C && manual_nrst_i
            |=> ext_line3_level_o == $past(wdata_i[3:0])
    ) else $error("write during standby was not taken");

    // Unmapped offsets must neither store nor answer
    a_unmapped_write: assert property (
        wr_i && !hit && manual_nrst_i |=> $stable(bank[0]) && $stable(bank[1])
            && $stable(bank[2]) && $stable(bank[3])
    ) else $error("write to an unmapped offset changed a register");

    a_unmapped_read: assert property (
        rd_i && !hit |=> rdata_o == 16'h0000
    ) else $error("read of an unmapped offset returned data");

    // ****************************************************************
    // Tie order checks
    // ****************************************************************
    a_dma_ch1_alone: assert property (
        dma_req_i == 2'h2 |-> dma_serve_o == 2'h2
    ) else $error("lone DMA channel 1 request not served");

    a_bus_state_alone: assert property (
        bus_state_req_i && !watchdog_req_i |-> bus_state_serve_o && !watchdog_serve_o
    ) else $error("lone bus-state request not served");

endmodule

// File: ipr_src_model.sv
`timescale 1ns/1ps

// ****************************************************************
// Request source model
// ****************************************************************
module ipr_src_model (
    // Clock
    input wire logic clk_i,
    // Scenario pattern: dma[1:0], watchdog, bus-state
    input wire logic [3:0] pat_i,
    // Request levels
    output logic [1:0] dma_req_o,
    output logic watchdog_req_o,
    output logic bus_state_req_o
);
    // Registered, so requests never change on the sampling edge
    always_ff @(posedge clk_i) begin
        {dma_req_o, watchdog_req_o, bus_state_req_o} <= pat_i;
    end
endmodule

// File: ipr_regs_tb.sv
`timescale 1ns/1ps
`include "ipr_cfg.svh"

module ipr_regs_tb;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic manual_nrst_i = 1'b1;
    logic standby_i = 1'b0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [3:0] pat = 4'h0;
    logic [15:0] wdata_i = 16'h0000;
    wire logic [15:0] rdata_o;
    wire logic [47:0] lv;
    wire logic [1:0] dma_req;
    wire logic [1:0] dma_serve;
    wire logic wd_req, bs_req, wd_serve, bs_serve;
    logic [15:0] sh [4] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
    localparam logic [15:0] MSK [4] = '{16'h0FF0, 16'hFF00, 16'hFFFF, 16'hFFFF};
    int fail_count = 0;
    int checks_done = 0;
    int cyc = 0;

    always #12.5 clk_i = ~clk_i;

    ipr_src_model SRC (.clk_i(clk_i), .pat_i(pat), .dma_req_o(dma_req),
        .watchdog_req_o(wd_req), .bus_state_req_o(bs_req));

    ipr_regs DUT (.clk_i(clk_i), .nrst_i(nrst_i), .manual_nrst_i(manual_nrst_i),
        .standby_i(standby_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .dma_req_i(dma_req), .watchdog_req_i(wd_req),
        .bus_state_req_i(bs_req), .dma_serve_o(dma_serve), .watchdog_serve_o(wd_serve),
        .bus_state_serve_o(bs_serve), .dma_level_o(lv[47:44]),
        .watchdog_level_o(lv[43:40]), .eth_dma_level_o(lv[39:36]),
        .freerun_timer_level_o(lv[35:32]), .ext_line0_level_o(lv[31:28]),
        .ext_line1_level_o(lv[27:24]), .ext_line2_level_o(lv[23:20]),
        .ext_line3_level_o(lv[19:16]), .pulse_timer0_level_o(lv[15:12]),
        .pulse_timer1_level_o(lv[11:8]), .pulse_timer2_level_o(lv[7:4]),
        .fifo_serial1_level_o(lv[3:0]));

    // ****************************************************************
    // Checking and bus tasks
    // ****************************************************************
    task automatic report_and_stop();
        if (fail_count == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [47:0] e, input logic [47:0] s);
        checks_done++;
        if (s !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask

    function automatic logic [47:0] exp_lv();
        return {sh[0][11:4], sh[1][15:8], sh[2], sh[3]};
    endfunction

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
        // Unmapped offsets leave the bank alone
        if (a < 4'h8 && !a[0]) sh[a[2:1]] = d & MSK[a[2:1]];
        #1 chk("levels", exp_lv(), lv);
    endtask

    task automatic rd(input logic [3:0] a);
        logic [15:0] e;
        e = (a < 4'h8 && !a[0]) ? sh[a[2:1]] : 16'h0000;
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk("rdata", {32'h0, e}, {32'h0, rdata_o});
        @(posedge clk_i);
        #1 chk("rdata idle", 48'h0, {32'h0, rdata_o});
    endtask

    task automatic rd_all();
        for (int i = 0; i < 4; i++) rd(4'(2 * i));
    endtask

    // Write then read with no gap between the strobes
    task automatic wr_rd(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        sh[a[2:1]] = d & MSK[a[2:1]];
        #1 chk("rdata back to back", {32'h0, sh[a[2:1]]}, {32'h0, rdata_o});
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_fields();
        logic [15:0] pats [4] = '{16'h5A5A, 16'h9C3F, 16'h1234, 16'hABCD};
        for (int i = 0; i < 4; i++) wr(4'(2 * i), 16'hFFFF);
        rd_all();
        for (int i = 0; i < 4; i++) wr(4'(2 * i), pats[i]);
        rd_all();
    endtask

    task automatic t_unmapped();
        wr(4'h1, 16'hFFFF);
        wr(4'h8, 16'hFFFF);
        wr(4'hE, 16'h0000);
        rd(4'h9);
        rd(4'hC);
        rd_all();
    endtask

    task automatic t_standby();
        @(posedge clk_i);
        standby_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        #1 chk("standby levels", exp_lv(), lv);
        wr(`IPR_OFS_C, 16'h0F0F);
        @(posedge clk_i);
        standby_i <= 1'b0;
        rd_all();
    endtask

    task automatic t_manual();
        @(posedge clk_i);
        manual_nrst_i <= 1'b0;
        wr_i <= 1'b1;
        addr_i <= `IPR_OFS_D;
        wdata_i <= 16'h7777;
        @(posedge clk_i);
        manual_nrst_i <= 1'b1;
        wr_i <= 1'b0;
        sh = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
        #1 chk("manual levels", 48'h0, lv);
        rd_all();
    endtask

    task automatic t_por();
        @(posedge clk_i);
        nrst_i <= 1'b0;
        @(posedge clk_i);
        sh = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
        nrst_i <= 1'b1;
        #1 chk("por levels", 48'h0, lv);
        rd_all();
    endtask

    task automatic t_serve();
        logic [1:0] ed;
        for (int i = 0; i < 16; i++) begin
            @(posedge clk_i);
            pat <= i[3:0];
            @(posedge clk_i);
            ed = i[2] ? 2'b01 : (i[3] ? 2'b10 : 2'b00);
            #1 chk("serve", {44'h0, ed, i[1], i[0] & ~i[1]},
                {44'h0, dma_serve, wd_serve, bs_serve});
        end
    endtask

    // Hang guard, well above the 173 cycles needed
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            report_and_stop();
        end
    end

    initial begin
        repeat (3) @(posedge clk_i);
        nrst_i <= 1'b1;
        rd_all();
        t_fields();
        wr_rd(`IPR_OFS_A, 16'hF5AF);
        wr_rd(`IPR_OFS_B, 16'h6C9F);
        wr_rd(`IPR_OFS_C, 16'h8E31);
        t_unmapped();
        t_standby();
        wr(`IPR_OFS_A, 16'h0CC0);
        t_manual();
        wr(`IPR_OFS_B, 16'h3300);
        t_por();
        t_serve();
        report_and_stop();
    end
endmodule
